// *** opmode_pkg.sv ***
// Constants and types shared by the operating mode pin selector.
package opmode_pkg;

	// ==========================================================
	// Register byte offsets on the Avalon-MM slave
	localparam logic [5:0] OFS_MODE_STATUS = 6'h00;
	localparam logic [5:0] OFS_SYS_CTRL    = 6'h04;
	localparam logic [5:0] OFS_PIN_FUNC    = 6'h08;
	localparam logic [5:0] OFS_AREA_WIDTH  = 6'h0C;
	localparam logic [5:0] OFS_PORT1       = 6'h10;
	localparam logic [5:0] OFS_PORTA       = 6'h14;
	localparam logic [5:0] OFS_PORTB       = 6'h18;
	localparam logic [5:0] OFS_PORTC       = 6'h1C;

	// ==========================================================
	// Field positions
	localparam int RAM_EN_BIT    = 0;
	localparam int MODE_VALID_BIT = 3;
	localparam int DR_LSB        = 8;

	// ==========================================================
	// Operating mode codes
	localparam logic [2:0] MODE_EXT_WIDE   = 3'h4;
	localparam logic [2:0] MODE_EXT_NARROW = 3'h5;
	localparam logic [2:0] MODE_ROM_EXT    = 3'h6;
	localparam logic [2:0] MODE_SINGLE     = 3'h7;

	// ==========================================================
	// Values after reset and after the mode is latched
	localparam logic [2:0] MODE_RST        = 3'h7;
	localparam logic       RAM_EN_RST      = 1'b1;
	localparam logic [3:0] AE_RST          = 4'h0;
	localparam logic [3:0] AE_RST_EXT      = 4'hC;
	localparam logic [3:0] AE_RST_ROM      = 4'h0;
	localparam logic [7:0] AREA_RST_WIDE   = 8'hFF;
	localparam logic [7:0] AREA_RST_NARROW = 8'h00;
	localparam logic [7:0] PORT_RST        = 8'h00;
	localparam logic [2:0] SETTLE_CYCLES   = 3'h4;

	// ==========================================================
	// Types
	typedef enum logic [0:0]
	{
		ST_SETTLE = 1'b0,
		ST_RUN    = 1'b1
	} latch_state_t;

	typedef struct packed
	{
		logic rom_enable;
		logic ext_enable;
		logic bus_wide;
		logic data_d;
		logic data_e;
		logic ctrl_f;
	} port_func_t;

	typedef struct packed
	{
		logic [23:0] out;
		logic [23:0] oe;
	} pin_drive_t;

endpackage

// *** pin_cell.sv ***
// One multiplexed port pin: address output or general port output, registered.
`timescale 1ns/1ns
module pin_cell
	import opmode_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic sel_addr,
	input  wire logic addr_bit,
	input  wire logic ddr_bit,
	input  wire logic dr_bit,
	output logic      out_reg,
	output logic      oe_reg
);

	logic out_next;
	logic oe_next;

	// Address selection overrides the direction bit entirely.
	always_comb
	begin
		out_next = sel_addr ? addr_bit : dr_bit;
		oe_next  = sel_addr | ddr_bit;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			out_reg <= 1'b0;
			oe_reg  <= 1'b0;
		end
		else
		begin
			out_reg <= out_next;
			oe_reg  <= oe_next;
		end
	end

endmodule

// *** opmode_pin_select.sv ***
// Operating mode latch and port 1, A to F pin function selection with Avalon-MM registers.
//
// Behaviour
// - Modes 4 and 5: advanced 16-Mbyte space, on-chip ROM off, all accesses external except enabled internal RAM.
// - Mode 6: on-chip ROM on, external accesses still allowed.
// - Mode 7: ROM on, no external access, every port is general I/O.
// - Modes 4 and 5: port1 upper pins, A, B, C address; D data, E data when 16-bit; F control.
// - Modes 4 and 5 after reset: port1 pins 13-11 inputs, A20-A8 driven.
// - Address-enable field gates each of A23-A8; disabled pins follow direction bits.
// - Modes 4 and 5: port C always drives A7-A0, never general I/O.
// - Mode 4 starts 16-bit; drops to 8-bit when every area is 8-bit.
// - Modes 5 and 6 start 8-bit; any 16-bit area makes bus and port E wide.
// - Mode 6 after reset: all address ports inputs; A23-A8 only via enable field.
// - Mode 6: each A7-A0 line drives port C only when its direction bit is set.
// - Modes 4 to 6: internal RAM disabled sends internal RAM range accesses to external memory.
// - Mode comes from the three mode pins; status bits are read-only.
`timescale 1ns/1ns
module opmode_pin_select
	import opmode_pkg::*;
#(
	parameter int          PIN_COUNT = 24,
	parameter logic [23:0] ROM_LIMIT = 24'h040000,
	parameter logic [23:0] RAM_BASE  = 24'hFFB000,
	parameter logic [23:0] RAM_LIMIT = 24'hFFF000
)
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [2:0]  mode_select_pins,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [23:0] cpu_addr,
	output logic             access_external_reg,
	output port_func_t       func_reg,
	output pin_drive_t       pins
);

	// ==========================================================
	// Mode pin synchroniser and one-time mode latch
	logic [2:0]   sync1_reg;
	logic [2:0]   sync2_reg;
	logic [2:0]   sync3_reg;
	latch_state_t state_reg;
	latch_state_t state_next;
	logic [2:0]   settle_reg;
	logic [2:0]   settle_next;
	logic [2:0]   mode_status_bits;
	logic [2:0]   mode_next;
	logic         latch_now;

	always_comb
	begin
		state_next  = state_reg;
		settle_next = settle_reg;
		mode_next   = mode_status_bits;
		latch_now   = 1'b0;
		case (state_reg)
			ST_SETTLE:
			begin
				if (settle_reg != SETTLE_CYCLES)
					settle_next = settle_reg + 3'h1;
				else if (sync2_reg == sync3_reg)
				begin
					// The mode is taken once and never again until reset.
					latch_now  = 1'b1;
					mode_next  = sync3_reg;
					state_next = ST_RUN;
				end
			end
			default:
			begin
				state_next = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1_reg        <= 3'h0;
			sync2_reg        <= 3'h0;
			sync3_reg        <= 3'h0;
			state_reg        <= ST_SETTLE;
			settle_reg       <= 3'h0;
			mode_status_bits <= MODE_RST;
		end
		else
		begin
			sync1_reg        <= mode_select_pins;
			sync2_reg        <= sync1_reg;
			sync3_reg        <= sync2_reg;
			state_reg        <= state_next;
			settle_reg       <= settle_next;
			mode_status_bits <= mode_next;
		end
	end

	// ==========================================================
	// Mode decode
	logic run;
	logic mode_ext45;
	logic mode_rom6;
	logic bus_wide;

	// Unlisted modes, and the time before the latch, behave as single-chip.
	assign run        = (state_reg == ST_RUN);
	assign mode_ext45 = run && (mode_status_bits == MODE_EXT_WIDE ||
	                            mode_status_bits == MODE_EXT_NARROW);
	assign mode_rom6  = run && (mode_status_bits == MODE_ROM_EXT);

	// ==========================================================
	// Avalon-MM slave and registers
	logic        ack_reg;
	logic        ack_next;
	logic [31:0] rdata_next;
	logic        internal_ram_enable;
	logic        ram_en_next;
	logic [3:0]  addr_out_enable_field;
	logic [3:0]  ae_next;
	logic [7:0]  area_wide_reg;
	logic [7:0]  area_next;
	logic [23:0] ddr_reg;
	logic [23:0] ddr_next;
	logic [23:0] dr_reg;
	logic [23:0] dr_next;
	logic        wr;

	// One wait state: every access completes on the second cycle it is held.
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign wr              = avs_write & ack_reg;

	always_comb
	begin
		ack_next    = (avs_read | avs_write) & ~ack_reg;
		rdata_next  = avs_readdata;
		ram_en_next = internal_ram_enable;
		ae_next     = addr_out_enable_field;
		area_next   = area_wide_reg;
		ddr_next    = ddr_reg;
		dr_next     = dr_reg;
		if (ack_next && avs_read)
		begin
			rdata_next = 32'h0000_0000;
			if (avs_address == OFS_MODE_STATUS)
				rdata_next = {28'h0, run, mode_status_bits};
			else if (avs_address == OFS_SYS_CTRL)
				rdata_next = {31'h0, internal_ram_enable};
			else if (avs_address == OFS_PIN_FUNC)
				rdata_next = {28'h0, addr_out_enable_field};
			else if (avs_address == OFS_AREA_WIDTH)
				rdata_next = {24'h0, area_wide_reg};
			else if (avs_address == OFS_PORT1)
				rdata_next = {20'h0, dr_reg[23:20], 4'h0, ddr_reg[23:20]};
			else if (avs_address == OFS_PORTA)
				rdata_next = {20'h0, dr_reg[19:16], 4'h0, ddr_reg[19:16]};
			else if (avs_address == OFS_PORTB)
				rdata_next = {16'h0, dr_reg[15:8], ddr_reg[15:8]};
			else if (avs_address == OFS_PORTC)
				rdata_next = {16'h0, dr_reg[7:0], ddr_reg[7:0]};
		end
		// Mode status has no write path at all.
		if (wr && avs_byteenable[0])
		begin
			if (avs_address == OFS_SYS_CTRL)
				ram_en_next = avs_writedata[RAM_EN_BIT];
			else if (avs_address == OFS_PIN_FUNC)
				ae_next = avs_writedata[3:0];
			else if (avs_address == OFS_AREA_WIDTH)
				area_next = avs_writedata[7:0];
			else if (avs_address == OFS_PORT1)
				ddr_next[23:20] = avs_writedata[3:0];
			else if (avs_address == OFS_PORTA)
				ddr_next[19:16] = avs_writedata[3:0];
			else if (avs_address == OFS_PORTB)
				ddr_next[15:8] = avs_writedata[7:0];
			else if (avs_address == OFS_PORTC)
				ddr_next[7:0] = avs_writedata[7:0];
		end
		if (wr && avs_byteenable[1])
		begin
			if (avs_address == OFS_PORT1)
				dr_next[23:20] = avs_writedata[DR_LSB+3:DR_LSB];
			else if (avs_address == OFS_PORTA)
				dr_next[19:16] = avs_writedata[DR_LSB+3:DR_LSB];
			else if (avs_address == OFS_PORTB)
				dr_next[15:8] = avs_writedata[DR_LSB+7:DR_LSB];
			else if (avs_address == OFS_PORTC)
				dr_next[7:0] = avs_writedata[DR_LSB+7:DR_LSB];
		end
		// The latch loads the mode's own start-up pin and width settings.
		if (latch_now)
		begin
			if (mode_next == MODE_EXT_WIDE || mode_next == MODE_EXT_NARROW)
				ae_next = AE_RST_EXT;
			else
				ae_next = AE_RST_ROM;
			if (mode_next == MODE_EXT_WIDE)
				area_next = AREA_RST_WIDE;
			else
				area_next = AREA_RST_NARROW;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ack_reg               <= 1'b0;
			avs_readdata          <= 32'h0000_0000;
			internal_ram_enable   <= RAM_EN_RST;
			addr_out_enable_field <= AE_RST;
			area_wide_reg         <= AREA_RST_NARROW;
			ddr_reg               <= {3{PORT_RST}};
			dr_reg                <= {3{PORT_RST}};
		end
		else
		begin
			ack_reg               <= ack_next;
			avs_readdata          <= rdata_next;
			internal_ram_enable   <= ram_en_next;
			addr_out_enable_field <= ae_next;
			area_wide_reg         <= area_next;
			ddr_reg               <= ddr_next;
			dr_reg                <= dr_next;
		end
	end

	// ==========================================================
	// Port functions and access routing
	port_func_t func_next;
	logic       access_ext_next;
	logic       in_rom;
	logic       in_ram;

	// Both wide-bus rules reduce to: wide while any area is 16-bit.
	assign bus_wide = |area_wide_reg;
	assign in_rom   = cpu_addr < ROM_LIMIT;
	assign in_ram   = cpu_addr >= RAM_BASE && cpu_addr < RAM_LIMIT;

	always_comb
	begin
		func_next.rom_enable = !mode_ext45;
		func_next.ext_enable = mode_ext45 | mode_rom6;
		func_next.bus_wide   = func_next.ext_enable & bus_wide;
		func_next.data_d     = func_next.ext_enable;
		func_next.data_e     = func_next.ext_enable & bus_wide;
		func_next.ctrl_f     = func_next.ext_enable;
		access_ext_next      = 1'b0;
		if (mode_ext45)
			access_ext_next = !(in_ram && internal_ram_enable);
		else if (mode_rom6)
			access_ext_next = !in_rom && !(in_ram && internal_ram_enable);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			func_reg            <= '0;
			access_external_reg <= 1'b0;
		end
		else
		begin
			func_reg            <= func_next;
			access_external_reg <= access_ext_next;
		end
	end

	// ==========================================================
	// Pin multiplexers: bits 23:20 port 1, 19:16 port A, 15:8 port B, 7:0 port C
	logic [4:0]           ae_lines;
	logic [PIN_COUNT-1:0] sel_addr;

	// Field value n enables n+1 lines upward from A8; zero enables none.
	assign ae_lines = (addr_out_enable_field == 4'h0) ? 5'h00 :
	                  {1'b0, addr_out_enable_field} + 5'h01;

	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++)
		begin : g_pin
			if (g < 8)
			begin : g_low
				assign sel_addr[g] = mode_ext45 | (mode_rom6 & ddr_reg[g]);
			end
			else
			begin : g_high
				assign sel_addr[g] = (mode_ext45 | mode_rom6) &&
				                     (5'(g - 8) < ae_lines);
			end
			pin_cell u_cell
			(
				.clk      (clk),
				.rst_b    (rst_b),
				.sel_addr (sel_addr[g]),
				.addr_bit (cpu_addr[g]),
				.ddr_bit  (ddr_reg[g]),
				.dr_bit   (dr_reg[g]),
				.out_reg  (pins.out[g]),
				.oe_reg   (pins.oe[g])
			);
		end
	endgenerate

	// ==========================================================
	// Assertions
	property p_rom_off_ext;
		@(posedge clk) disable iff (!rst_b)
		mode_ext45 |=> !func_reg.rom_enable && func_reg.ext_enable;
	endproperty
	a_rom_off_ext: assert property (p_rom_off_ext) else $error("ROM on in external mode");

	property p_rom_on_six;
		@(posedge clk) disable iff (!rst_b)
		mode_rom6 |=> func_reg.rom_enable && func_reg.ext_enable;
	endproperty
	a_rom_on_six: assert property (p_rom_on_six) else $error("Mode 6 function wrong");

	property p_single_chip;
		@(posedge clk) disable iff (!rst_b)
		run && !mode_ext45 && !mode_rom6 |=> !access_external_reg
		&& pins.oe == $past(ddr_reg);
	endproperty
	a_single_chip: assert property (p_single_chip) else $error("Mode 7 not general I/O");

	property p_portc_addr;
		@(posedge clk) disable iff (!rst_b)
		mode_ext45 |=> pins.oe[7:0] == 8'hFF && pins.out[7:0] == $past(cpu_addr[7:0]);
	endproperty
	a_portc_addr: assert property (p_portc_addr) else $error("Port C not address");

	property p_start_ext;
		@(posedge clk) disable iff (!rst_b)
		$rose(run) && mode_ext45 |=> pins.oe[23:8] == {3'h0, 13'h1FFF};
	endproperty
	a_start_ext: assert property (p_start_ext) else $error("A20-A8 not driven at start");

	property p_start_six;
		@(posedge clk) disable iff (!rst_b)
		$rose(run) && mode_rom6 |-> addr_out_enable_field == AE_RST_ROM
		&& area_wide_reg == AREA_RST_NARROW ##1 pins.oe == $past(ddr_reg);
	endproperty
	a_start_six: assert property (p_start_six) else $error("Mode 6 start state wrong");

	property p_wide_start;
		@(posedge clk) disable iff (!rst_b)
		$rose(run) && mode_status_bits == MODE_EXT_WIDE |=> func_reg.bus_wide;
	endproperty
	a_wide_start: assert property (p_wide_start) else $error("Mode 4 not 16-bit");

	property p_wide_any;
		@(posedge clk) disable iff (!rst_b)
		mode_rom6 && area_wide_reg != 8'h00 |=> func_reg.data_e && func_reg.bus_wide;
	endproperty
	a_wide_any: assert property (p_wide_any) else $error("Port E not data when wide");

	property p_portc_six;
		@(posedge clk) disable iff (!rst_b)
		mode_rom6 |=> pins.oe[7:0] == $past(ddr_reg[7:0]);
	endproperty
	a_portc_six: assert property (p_portc_six) else $error("Port C drive wrong");

	property p_ram_off;
		@(posedge clk) disable iff (!rst_b)
		mode_ext45 && !internal_ram_enable && in_ram |=> access_external_reg;
	endproperty
	a_ram_off: assert property (p_ram_off) else $error("RAM range not external");

	property p_mode_fixed;
		@(posedge clk) disable iff (!rst_b)
		run |=> run && $stable(mode_status_bits);
	endproperty
	a_mode_fixed: assert property (p_mode_fixed) else $error("Mode changed after latch");

	c_mode_ext: cover property (@(posedge clk) disable iff (!rst_b) $rose(mode_ext45));
	c_mode_six: cover property (@(posedge clk) disable iff (!rst_b) $rose(mode_rom6));
	c_narrow:   cover property (@(posedge clk) disable iff (!rst_b) $fell(func_reg.bus_wide));

endmodule

// *** ext_bus_model.sv ***
// External memory side of the address bus: rebuilds the address seen on the pins.
`timescale 1ns/1ns
module ext_bus_model
	import opmode_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire pin_drive_t  pins,
	output logic [23:0]      bus_addr
);
	// ==========================================================
	// Pin levels
	// Undriven lines show the inverse of their last level, so a stale value never matches.
	logic [23:0] last_reg;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			last_reg <= 24'h000000;
		else
			last_reg <= bus_addr;
	end

	assign bus_addr = (pins.out & pins.oe) | (~last_reg & ~pins.oe);
endmodule

// *** operating_mode_pin_select_test.sv ***
// Register and pin level tests of the operating mode pin selector.
`timescale 1ns/1ns
module operating_mode_pin_select_test;
	import opmode_pkg::*;

	logic        clk;
	logic        rst_b;
	logic [2:0]  mode_select_pins;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [23:0] cpu_addr;
	logic        access_external_reg;
	port_func_t  func_reg;
	pin_drive_t  pins;
	logic [23:0] bus_addr;
	int          failures;
	int          n_checks;
	int          cycles;
	logic [31:0] d;
	logic [23:0] oe_x;
	logic        ext;
	logic        wide;

	opmode_pin_select uut (.clk(clk), .rst_b(rst_b), .mode_select_pins(mode_select_pins),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cpu_addr(cpu_addr), .access_external_reg(access_external_reg),
		.func_reg(func_reg), .pins(pins));

	ext_bus_model mem (.clk(clk), .rst_b(rst_b), .pins(pins), .bus_addr(bus_addr));

	initial clk = 1'b0;
	always #10 clk = ~clk;

	// ==========================================================
	// Timeout
	always @(posedge clk)
	begin
		cycles = cycles + 1;
		if (cycles == 40000)
		begin
			failures = failures + 1;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// Compare tasks
	task automatic chk_reg(string what, logic [31:0] exp, logic [31:0] got);
		n_checks = n_checks + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_pin(string what, logic [23:0] exp, logic [23:0] got);
		n_checks = n_checks + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ==========================================================
	// Avalon-MM accesses; waitrequest and readdata are taken at the rising edge itself.
	task automatic bus(logic wr, logic [5:0] a, logic [31:0] wd, output logic [31:0] rd);
		avs_read      <= ~wr;
		avs_write     <= wr;
		avs_address   <= a;
		avs_writedata <= wd;
		do
		begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(logic [5:0] a, output logic [31:0] v);
		bus(1'b0, a, 32'h00000000, v);
	endtask

	task automatic wr(logic [5:0] a, logic [31:0] v);
		logic [31:0] x;
		bus(1'b1, a, v, x);
	endtask

	// Pins and routing answer one cycle after their inputs; two edges leave margin.
	task automatic pin_chk(logic [23:0] a, logic [23:0] oe, logic [23:0] out, logic ex);
		cpu_addr <= a;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk_pin("pins.oe", oe, pins.oe);
		chk_pin("pins.out", out, pins.out);
		chk_pin("bus_addr", out & oe, bus_addr & oe);
		chk_reg("access_external", {31'h0, ex}, {31'h0, access_external_reg});
		@(posedge clk);
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		rst_b = 1'b0;
		mode_select_pins = 3'h4;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		cpu_addr = 24'h000000;
		failures = 0;
		n_checks = 0;
		cycles = 0;
		for (int m = 4; m < 8; m++)
		begin
			@(posedge clk);
			rst_b <= 1'b0;
			mode_select_pins <= m[2:0];
			repeat (16) @(posedge clk);
			rst_b <= 1'b1;
			d = 32'h00000000;
			for (int i = 0; i < 20 && d[MODE_VALID_BIT] !== 1'b1; i++)
				rd(OFS_MODE_STATUS, d);
			ext  = (m != 7);
			wide = (m == 4);
			oe_x = (m < 6) ? 24'h1FFFFF : 24'h000000;
			chk_reg("mode_status", {28'h0, 1'b1, m[2:0]}, d);
			wr(OFS_MODE_STATUS, 32'h00000000);
			rd(OFS_MODE_STATUS, d);
			chk_reg("mode_status ro", {28'h0, 1'b1, m[2:0]}, d);
			chk_reg("func", {26'h0, m > 5, ext, wide, ext, wide, ext}, {26'h0, func_reg});
			rd(OFS_SYS_CTRL, d);
			chk_reg("system_ctrl_reg", 32'h00000001, d);
			rd(OFS_PIN_FUNC, d);
			chk_reg("addr_out_enable_field", (m < 6) ? 32'h0000000C : 32'h00000000, d);
			rd(OFS_AREA_WIDTH, d);
			chk_reg("area_width", wide ? 32'h000000FF : 32'h00000000, d);
			rd(6'h20, d);
			chk_reg("unmapped", 32'h00000000, d);
			pin_chk(24'h123456, oe_x, 24'h123456 & oe_x, ext);
			if (m < 6)
				chk_pin("bus low byte", {16'h0, 8'h56}, {16'h0, bus_addr[7:0]});
			pin_chk(24'h000100, oe_x, 24'h000100 & oe_x, m < 6);
			pin_chk(24'hFFC000, oe_x, 24'hFFC000 & oe_x, 1'b0);
			wr(OFS_SYS_CTRL, 32'h00000000);
			pin_chk(24'hFFC000, oe_x, 24'hFFC000 & oe_x, ext);
			if (m == 4)
			begin
				wr(OFS_AREA_WIDTH, 32'h00000000);
				@(posedge clk);
				chk_reg("func narrow", 32'h00000015, {26'h0, func_reg});
				wr(OFS_AREA_WIDTH, 32'h00000001);
				@(posedge clk);
				chk_reg("func wide", 32'h0000001F, {26'h0, func_reg});
				wr(OFS_PIN_FUNC, 32'h00000000);
				wr(OFS_PORTB, 32'h0000A5FF);
				pin_chk(24'h123456, 24'h00FFFF, 24'h00A556, 1'b1);
				wr(OFS_PIN_FUNC, 32'h0000000F);
				pin_chk(24'hABCDEF, 24'hFFFFFF, 24'hABCDEF, 1'b1);
			end
			if (m == 5 || m == 6)
			begin
				wr(OFS_AREA_WIDTH, 32'h00000010);
				@(posedge clk);
				chk_reg("func wide", {26'h0, m == 6, 5'h1F}, {26'h0, func_reg});
			end
			if (m == 6)
			begin
				wr(OFS_PORTC, 32'h0000000F);
				pin_chk(24'h123456, 24'h00000F, 24'h000006, 1'b1);
				wr(OFS_PIN_FUNC, 32'h00000003);
				pin_chk(24'h123456, 24'h000F0F, 24'h000406, 1'b1);
			end
			if (m == 7)
			begin
				wr(OFS_PORT1, 32'h0000090F);
				pin_chk(24'h123456, 24'hF00000, 24'h900000, 1'b0);
				mode_select_pins <= 3'h4;
				repeat (8) @(posedge clk);
				rd(OFS_MODE_STATUS, d);
				chk_reg("mode held", 32'h0000000F, d);
			end
			$display("mode %0d test done", m);
		end
		test_done();
	end
endmodule
